// ### hdl/ade_exec.v
/*
 * ade_exec.v
 * holds: execution slice for add-with-carry, absolute page jump and byte and,
 *        with its own accumulator, status word, program counter, 128-byte data
 *        memory and four output port latches, reached over classic wishbone.
 * assumes: one clock, synchronous active-high reset, one clock per machine cycle,
 *          port pins synchronous to clk_i.
 */
// Behaviour
// - add-with-carry puts accumulator plus operand plus carry into the accumulator.
// - carry set on carry out of bit 7, aux carry on bit 3.
// - overflow set when exactly one of carries out of bits 6, 7.
// - add-with-carry takes register, direct, indirect, immediate; register/indirect one byte.
// - page jump: counter plus two, keep top five bits, low eleven from instruction.
// - page jump decoded from low five opcode bits 00001, two bytes, two cycles.
// - byte and stores result in destination; only parity may change, except with the status word as destination.
// - byte and has four accumulator forms and two direct-destination forms.
// - byte and with an output port as direct destination reads the port latch; the accumulator form with a port source reads the pins.
// - parity always follows the present accumulator content.
`timescale 1ns/1ps
`default_nettype none
`include "ade_defines.vh"

module ade_exec (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // port pins and latches
   input wire [31:0] port_pins_i,
   output wire [31:0] port_out_o,
   // execution state
   output reg busy_o
);

   localparam ST_IDLE = 2'd0;
   localparam ST_EXEC = 2'd1;
   localparam ST_WAIT = 2'd2;

   reg [1:0] state_ff;
   reg [7:0] acc_ff;
   reg [7:0] psw_ff;
   reg [15:0] pc_ff;
   reg [7:0] op_ff;
   reg [7:0] b2_ff;
   reg [7:0] b3_ff;
   reg [6:0] raddr_ff;
   reg done_ff;
   reg ill_ff;
   reg [31:0] latch_ff;
   reg [7:0] ram [0:`ADE_RAM_WORDS-1];

   wire parity = ^acc_ff;
   wire [7:0] psw_rd = {psw_ff[7:1], parity};
   wire is_add_with_carry_op = (op_ff[7:4] == `ADE_GRP_ADD_WITH_CARRY_OP) && (op_ff[3:2] != 2'b00);
   wire is_and = (op_ff[7:4] == `ADE_GRP_AND) && (op_ff[3:1] != 3'b000);
   wire is_jmp = (op_ff[4:0] == `ADE_JMP_PAT);
   wire and_dir = (op_ff == `ADE_OP_AND_DA) || (op_ff == `ADE_OP_AND_DI);
   wire is_port = (b2_ff[7:6] == `ADE_PORT_HI) && (b2_ff[3:0] == `ADE_PORT_LO);
   wire [1:0] port_idx = b2_ff[5:4];
   wire bus_req = wb_cyc_i && wb_stb_i;
   wire bus_wr = bus_req && wb_we_i && wb_ack_o;

   assign port_out_o = latch_ff;

   // ---------------------------------------------------------------
   // operand fetch
   // ---------------------------------------------------------------
   reg [7:0] dir_rd;
   reg [7:0] src;
   reg [7:0] ptr;
   // direct byte read; read-modify-write of a port takes the latch
   always @* begin
      dir_rd = 8'h00;
      if (!b2_ff[7]) begin
         dir_rd = ram[b2_ff[6:0]];
      end else if (is_port) begin
         if (and_dir) begin
            dir_rd = latch_ff[port_idx*8 +: 8];
         end else begin
            dir_rd = port_pins_i[port_idx*8 +: 8];
         end
      end else if (b2_ff == `ADE_SFR_ACC) begin
         dir_rd = acc_ff;
      end else if (b2_ff == `ADE_SFR_PSW) begin
         dir_rd = psw_rd;
      end
   end

   // source operand by low opcode nibble: immediate, direct, indirect, register
   always @* begin
      ptr = ram[{6'h00, op_ff[0]}];
      if (op_ff[3]) begin
         src = ram[{4'h0, op_ff[2:0]}];
      end else if (op_ff[3:1] == 3'b011) begin
         src = ram[ptr[6:0]];
      end else if (op_ff[3:0] == `ADE_SRC_DIR) begin
         src = dir_rd;
      end else begin
         src = b2_ff;
      end
   end

   // ---------------------------------------------------------------
   // execute
   // ---------------------------------------------------------------
   reg [7:0] nxt_acc;
   reg [7:0] nxt_psw;
   reg [15:0] nxt_pc;
   reg [15:0] pc_inc;
   reg [8:0] sum;
   reg [4:0] sum_lo;
   reg [7:0] sum_6;
   reg [7:0] and_res;
   reg dir_we;
   reg legal;
   reg two_cyc;
   always @* begin
      nxt_acc = acc_ff;
      nxt_psw = psw_ff;
      nxt_pc = pc_ff;
      pc_inc = pc_ff + 16'h0001;
      dir_we = 1'b0;
      legal = 1'b1;
      two_cyc = 1'b0;
      sum = {1'b0, acc_ff} + {1'b0, src} + {8'h00, psw_ff[`ADE_PSW_CY]};
      sum_lo = {1'b0, acc_ff[3:0]} + {1'b0, src[3:0]} + {4'h0, psw_ff[`ADE_PSW_CY]};
      sum_6 = {1'b0, acc_ff[6:0]} + {1'b0, src[6:0]} + {7'h00, psw_ff[`ADE_PSW_CY]};
      and_res = 8'h00;
      if (is_add_with_carry_op) begin
         // register and indirect forms are one byte
         // direct and immediate forms are two bytes
         if (op_ff[3:1] == 3'b010) begin
            pc_inc = pc_ff + 16'h0002;
         end
         nxt_pc = pc_inc;
         nxt_acc = sum[7:0];
         nxt_psw[`ADE_PSW_CY] = sum[8];
         nxt_psw[`ADE_PSW_AC] = sum_lo[4];
         // overflow from bit 6 and bit 7 carries
         nxt_psw[`ADE_PSW_OV] = sum[8] ^ sum_6[7];
      end else if (is_jmp) begin
         two_cyc = 1'b1;
         // page address into low eleven bits
         pc_inc = pc_ff + 16'h0002;
         nxt_pc = {pc_inc[15:11], op_ff[7:5], b2_ff};
      end else if (is_and) begin
         if (and_dir) begin
            if (op_ff == `ADE_OP_AND_DI) begin
               two_cyc = 1'b1;
               pc_inc = pc_ff + 16'h0003;
               and_res = dir_rd & b3_ff;
            end else begin
               pc_inc = pc_ff + 16'h0002;
               and_res = dir_rd & acc_ff;
            end
            // flags untouched unless the target is acc or the status word
            if (b2_ff == `ADE_SFR_ACC) begin
               nxt_acc = and_res;
            end else if (b2_ff == `ADE_SFR_PSW) begin
               nxt_psw = and_res;
            end else begin
               dir_we = 1'b1;
            end
         end else begin
            if (op_ff[3:1] == 3'b010) begin
               pc_inc = pc_ff + 16'h0002;
            end
            and_res = acc_ff & src;
            nxt_acc = and_res;
         end
         nxt_pc = pc_inc;
      end else begin
         legal = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // state, registers and bus writes
   // ---------------------------------------------------------------
   wire commit = ((state_ff == ST_EXEC) && legal && !two_cyc) || (state_ff == ST_WAIT);
   wire idle = (state_ff == ST_IDLE);
   wire go_wr = bus_wr && idle && (wb_adr_i == `ADE_REG_CTRL) && wb_sel_i[0]
      && wb_dat_i[`ADE_CTRL_GO];

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
         acc_ff <= `ADE_ACC_RST;
         psw_ff <= `ADE_PSW_RST;
         pc_ff <= `ADE_PC_RST;
         op_ff <= 8'h00;
         b2_ff <= 8'h00;
         b3_ff <= 8'h00;
         raddr_ff <= 7'h00;
         done_ff <= 1'b0;
         ill_ff <= 1'b0;
         latch_ff <= {4{`ADE_LATCH_RST}};
         busy_o <= 1'b0;
      end else begin
         // sequencer: one clock per machine cycle
         case (state_ff)
            ST_IDLE: begin
               if (go_wr) begin
                  state_ff <= ST_EXEC;
                  busy_o <= 1'b1;
                  done_ff <= 1'b0;
                  ill_ff <= 1'b0;
               end
            end
            ST_EXEC: begin
               if (!legal) begin
                  state_ff <= ST_IDLE;
                  busy_o <= 1'b0;
                  ill_ff <= 1'b1;
               end else if (two_cyc) begin
                  state_ff <= ST_WAIT;
               end else begin
                  state_ff <= ST_IDLE;
                  busy_o <= 1'b0;
                  done_ff <= 1'b1;
               end
            end
            ST_WAIT: begin
               state_ff <= ST_IDLE;
               busy_o <= 1'b0;
               done_ff <= 1'b1;
            end
            default: begin
               state_ff <= ST_IDLE;
               busy_o <= 1'b0;
            end
         endcase
         if (commit) begin
            acc_ff <= nxt_acc;
            psw_ff <= nxt_psw;
            pc_ff <= nxt_pc;
            if (dir_we && b2_ff[7] && is_port) begin
               latch_ff[port_idx*8 +: 8] <= and_res;
            end
         end else if (bus_wr && idle) begin
            // software writes only while no instruction runs
            case (wb_adr_i)
               `ADE_REG_INSTR: begin
                  if (wb_sel_i[0]) op_ff <= wb_dat_i[7:0];
                  if (wb_sel_i[1]) b2_ff <= wb_dat_i[15:8];
                  if (wb_sel_i[2]) b3_ff <= wb_dat_i[23:16];
               end
               `ADE_REG_ACC: if (wb_sel_i[0]) acc_ff <= wb_dat_i[7:0];
               `ADE_REG_PSW: if (wb_sel_i[0]) psw_ff <= wb_dat_i[7:0];
               `ADE_REG_PC: begin
                  if (wb_sel_i[0]) pc_ff[7:0] <= wb_dat_i[7:0];
                  if (wb_sel_i[1]) pc_ff[15:8] <= wb_dat_i[15:8];
               end
               `ADE_REG_RADDR: if (wb_sel_i[0]) raddr_ff <= wb_dat_i[6:0];
               `ADE_REG_PORTS: begin
                  if (wb_sel_i[0]) latch_ff[7:0] <= wb_dat_i[7:0];
                  if (wb_sel_i[1]) latch_ff[15:8] <= wb_dat_i[15:8];
                  if (wb_sel_i[2]) latch_ff[23:16] <= wb_dat_i[23:16];
                  if (wb_sel_i[3]) latch_ff[31:24] <= wb_dat_i[31:24];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // data memory: instruction result or software window
   always @(posedge clk_i) begin
      if (commit && dir_we && !b2_ff[7]) begin
         ram[b2_ff[6:0]] <= and_res;
      end else if (bus_wr && idle && (wb_adr_i == `ADE_REG_RDATA) && wb_sel_i[0]) begin
         ram[raddr_ff] <= wb_dat_i[7:0];
      end
   end

   // ---------------------------------------------------------------
   // wishbone answer: ack one cycle after the request, then drop
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req && !wb_ack_o;
         wb_dat_o <= 32'h00000000;
         if (bus_req && !wb_ack_o && !wb_we_i) begin
            case (wb_adr_i)
               `ADE_REG_CTRL: wb_dat_o <= {29'h0, ill_ff, done_ff, busy_o};
               `ADE_REG_INSTR: wb_dat_o <= {8'h00, b3_ff, b2_ff, op_ff};
               `ADE_REG_ACC: wb_dat_o <= {24'h0, acc_ff};
               `ADE_REG_PSW: wb_dat_o <= {24'h0, psw_rd};
               `ADE_REG_PC: wb_dat_o <= {16'h0, pc_ff};
               `ADE_REG_RADDR: wb_dat_o <= {25'h0, raddr_ff};
               `ADE_REG_RDATA: wb_dat_o <= {24'h0, ram[raddr_ff]};
               `ADE_REG_PORTS: wb_dat_o <= latch_ff;
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // ade_exec
`default_nettype wire

// ### pkg/ade_defines.vh
/*
 * ade_defines.vh
 * holds: constants of the exec slice: bus map, opcodes, flag bits, data addresses.
 * assumes: included by bare name; definitions only.
 */
`ifndef ADE_DEFINES_VH
`define ADE_DEFINES_VH

// ---------------------------------------------------------------
// register map (byte addresses on the wishbone bus)
// ---------------------------------------------------------------
`define ADE_REG_CTRL 8'h00
`define ADE_REG_INSTR 8'h04
`define ADE_REG_ACC 8'h08
`define ADE_REG_PSW 8'h0C
`define ADE_REG_PC 8'h10
`define ADE_REG_RADDR 8'h14
`define ADE_REG_RDATA 8'h18
`define ADE_REG_PORTS 8'h1C

// ---------------------------------------------------------------
// control and status bits
// ---------------------------------------------------------------
`define ADE_CTRL_GO 0
`define ADE_STAT_BUSY 0
`define ADE_STAT_DONE 1
`define ADE_STAT_ILL 2

// ---------------------------------------------------------------
// status word bits and reset values
// ---------------------------------------------------------------
`define ADE_PSW_CY 7
`define ADE_PSW_AC 6
`define ADE_PSW_OV 2
`define ADE_PSW_P 0
`define ADE_PSW_RST 8'h00
`define ADE_ACC_RST 8'h00
`define ADE_PC_RST 16'h0000
`define ADE_LATCH_RST 8'hFF

// ---------------------------------------------------------------
// opcodes and opcode fields
// ---------------------------------------------------------------
`define ADE_GRP_ADD_WITH_CARRY_OP 4'h3
`define ADE_GRP_AND 4'h5
`define ADE_SRC_IMM 4'h4
`define ADE_SRC_DIR 4'h5
`define ADE_OP_AND_DA 8'h52
`define ADE_OP_AND_DI 8'h53
`define ADE_JMP_PAT 5'b00001

// ---------------------------------------------------------------
// direct data addresses
// ---------------------------------------------------------------
`define ADE_SFR_ACC 8'hE0
`define ADE_SFR_PSW 8'hD0
`define ADE_PORT_HI 2'b10
`define ADE_PORT_LO 4'h0
`define ADE_RAM_WORDS 128

`endif

// ### test/ade_exec_checker.sv
/* ade_exec_checker.sv: port assertions for the exec slice.
   assumes: bound to ade_exec, one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module ade_exec_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // ports and state
   input wire logic [31:0] port_pins_i,
   input wire logic [31:0] port_out_o,
   input wire logic busy_o
);
   // ------------------------------------------
   // properties
   // ------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   AST_ACK_TAKE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   AST_RST: assert property ($fell(rst_i) |-> !wb_ack_o && !busy_o && port_out_o == 32'hFFFFFFFF)
      else $error("bad state after reset");
   AST_BUSY_MAX: assert property (busy_o [*2] |=> !busy_o)
      else $error("busy longer than two cycles");
   AST_BUSY_GO: assert property ($rose(busy_o) |-> $past(wb_we_i && wb_adr_i == 8'h00 && wb_dat_i[0])
      || $past(wb_we_i && wb_adr_i == 8'h00 && wb_dat_i[0], 2))
      else $error("busy without go write");
   AST_LATCH: assert property ($changed(port_out_o) |-> $past(busy_o) || $past(wb_ack_o && wb_we_i))
      else $error("port latch changed by itself");
endmodule // ade_exec_checker
`default_nettype wire

// ### test/ade_pin_model.sv
/* ade_pin_model.sv: far side of the port pins.
   assumes: pins are driven against the latches so a pin read differs. */
`timescale 1ns/1ps
`default_nettype none
module ade_pin_model (
   // latches in
   input wire logic [31:0] port_out_i,
   // pins out
   output logic [31:0] port_pins_o
);
   assign port_pins_o = ~port_out_i;
endmodule // ade_pin_model
`default_nettype wire

// ### test/testbench.sv
/* testbench.sv: self-checking bench for the exec slice.
   assumes: 100 MHz clock, sync reset, pin model on the ports. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module testbench;
   logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, port_pins_i, port_out_o, e;
   logic wb_ack_o, busy_o, cy, ac, ov;
   logic [31:0] exp_q[$];
   int miscompares = 0, compares = 0, seed = 95, n, k, len;
   logic [7:0] acc, b, p, op, b2, msk, m[0:127], lat[0:3];
   logic [3:0] g;
   logic [2:0] r;
   logic [1:0] q;
   logic [15:0] pc;
   always #5 clk_i = ~clk_i;
   ade_exec u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_pins_i(port_pins_i),
      .port_out_o(port_out_o), .busy_o(busy_o));
   ade_pin_model u_pins (.port_out_i(port_out_o), .port_pins_o(port_pins_i));
   // compares each read answer with the oldest note
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hDEADBEEF;
         `CHK(wb_dat_o, e)
      end
   end
   // one classic cycle, held until ack
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] v);
      exp_q.push_back(v);
      bus(0, a, 32'h0);
   endtask
   task automatic setm(input logic [7:0] a, input logic [7:0] d);
      bus(1, 8'h14, {24'h0, a});
      bus(1, 8'h18, {24'h0, d});
      m[a[6:0]] = d;
   endtask
   function automatic logic [31:0] psw();
      psw = {24'h0, cy, ac, 3'h0, ov, 1'b0, ^acc};
   endfunction
   task automatic add_with_carry_op(input logic [7:0] v);
      logic [8:0] s;
      logic [7:0] l;
      logic [4:0] h;
      s = acc + v + cy;
      l = acc[6:0] + v[6:0] + cy;
      h = acc[3:0] + v[3:0] + cy;
      ov = s[8] ^ l[7];
      cy = s[8];
      ac = h[4];
      acc = s[7:0];
   endtask
   // starts one instruction and counts its busy cycles
   task automatic run(input logic [7:0] o, c2, c3, input int ln, cyc, input logic j);
      bus(1, 8'h04, {8'h00, c3, c2, o});
      bus(1, 8'h00, 32'h1);
      n = 0;
      repeat (6) begin
         @(posedge clk_i);
         n += (busy_o === 1'b1);
      end
      `CHK(n, cyc)
      pc = pc + 16'(ln);
      if (j) pc[10:0] = {o[7:5], c2};
      rd(8'h10, {16'h0, pc});
      rd(8'h00, 32'h2);
   endtask
   task automatic final_report();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      final_report();
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      pc = 16'h0;
      rd(8'h08, 32'h0);
      rd(8'h0C, 32'h0);
      rd(8'h1C, 32'hFFFFFFFF);
      rd(8'h20, 32'h0);
      // every add and and form, ports and memory
      for (int i = 0; i < 48; i++) begin
         k = i % 12;
         {acc, cy, ac, ov} = 11'($random(seed));
         {lat[3], lat[2], lat[1], lat[0]} = $random(seed);
         {b, msk, r, q} = 21'($random(seed));
         p = {1'b0, 7'($random(seed)) | 7'h08};
         bus(1, 8'h08, {24'h0, acc});
         bus(1, 8'h0C, {24'h0, cy, ac, 3'h0, ov, 2'h0});
         bus(1, 8'h1C, {lat[3], lat[2], lat[1], lat[0]});
         setm(p, b);
         rd(8'h0C, psw());
         g = (k < 4) ? 4'h3 : 4'h5;
         b2 = p;
         len = 2;
         if (k < 8) begin
            case (k % 4)
               0: begin setm({5'h0, r}, b); op = {g, 1'b1, r}; len = 1; end
               1: begin setm({7'h0, r[0]}, p); op = {g, 3'h3, r[0]}; len = 1; end
               2: op = {g, 4'h5};
               default: begin op = {g, 4'h4}; b2 = b; end
            endcase
         end else begin
            op = k[0] ? 8'h53 : 8'h52;
            if (k >= 10) b2 = {2'b10, q, 4'h0};
            if (k[0]) len = 3;
         end
         run(op, b2, msk, len, (op == 8'h53) ? 2 : 1, 0);
         if (k < 4) add_with_carry_op(b);
         else if (k < 8) acc = acc & b;
         else if (k < 10) m[p[6:0]] = m[p[6:0]] & (k[0] ? msk : acc);
         else lat[q] = lat[q] & (k[0] ? msk : acc);
         rd(8'h08, {24'h0, acc});
         rd(8'h0C, psw());
         bus(1, 8'h14, {24'h0, p});
         rd(8'h18, {24'h0, m[p[6:0]]});
         rd(8'h1C, {lat[3], lat[2], lat[1], lat[0]});
         `CHK(port_out_o, {lat[3], lat[2], lat[1], lat[0]})
      end
      // page jump for each page field, one crossing a page
      for (int a = 0; a < 8; a++) begin
         pc = 16'($random(seed));
         if (a == 7) pc[10:0] = 11'h7FE;
         bus(1, 8'h10, {16'h0, pc});
         b = 8'($random(seed));
         run({3'(a), 5'b00001}, b, 8'h00, 2, 2, 1);
      end
      // undecoded opcode: illegal flag set, counter and accumulator left alone
      bus(1, 8'h04, 32'h0);
      bus(1, 8'h00, 32'h1);
      repeat (4) @(posedge clk_i);
      rd(8'h00, 32'h4);
      rd(8'h10, {16'h0, pc});
      // plain direct read of a port takes the pins, which oppose the latch
      run(8'h35, 8'h90, 8'h00, 2, 1, 0);
      add_with_carry_op(~lat[1]);
      rd(8'h08, {24'h0, acc});
      rd(8'h0C, psw());
      repeat (2) @(posedge clk_i);
      final_report();
   end
endmodule // testbench
bind ade_exec ade_exec_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .port_pins_i(port_pins_i), .port_out_o(port_out_o), .busy_o(busy_o));
`default_nettype wire
